// ---- hw/cas_pkg.sv ----
// ============================================================
// constants and types for the cell and aux conversion sequencer
package cas_pkg;

    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned NS_PER_US = 1000;
    // cycles per microsecond, derived from the clock rate
    localparam int unsigned CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;

    // reference power-up wait; no figure given, plain default
    localparam int unsigned REFUP_US = 5000;

    localparam int unsigned NUM_MODES = 8;
    localparam int unsigned NUM_CELLS = 12;
    localparam int unsigned HALF_CELLS = 6;
    localparam int unsigned NUM_AUX = 6;
    localparam int unsigned RES_DEPTH = 18;
    localparam int unsigned AUX_BASE = 12;
    localparam int unsigned TIME_W = 32;

    // filter modes: 27k, 14k, 7k, 3k, 2k, 1k, 422, 26 Hz
    // all-channel sequence: end of first slot, end of measuring, total
    localparam int unsigned ALL_T1M_US [NUM_MODES] =
        '{57, 86, 144, 260, 493, 959, 1890, 29817};
    localparam int unsigned ALL_T6M_US [NUM_MODES] =
        '{290, 465, 814, 1512, 2908, 5701, 11287, 178850};
    localparam int unsigned ALL_T6C_US [NUM_MODES] =
        '{1113, 1288, 2335, 3033, 4430, 7222, 12807, 201317};
    // single pair or single aux input
    localparam int unsigned ONE_T1M_US [NUM_MODES] =
        '{57, 86, 144, 240, 493, 959, 1890, 29817};
    localparam int unsigned ONE_T1C_US [NUM_MODES] =
        '{201, 230, 405, 501, 754, 1219, 2150, 33568};

    localparam logic [15:0] RESULT_MAX = 16'hDFFF;
    localparam logic [15:0] FAULT_BASE = 16'hFF00;
    localparam logic [2:0] CELL_SEL_ALL = 3'h0;
    localparam logic [2:0] AUX_SEL_REF2 = 3'h5;
    localparam logic [2:0] AUX_SEL_ALL = 3'h6;

    typedef enum logic [1:0] {
        CAS_CMD_CELLS = 2'h0,
        CAS_CMD_AUX = 2'h1,
        CAS_CMD_AUX_RED = 2'h2
    } cas_kind_type;

    typedef struct packed {
        cas_kind_type kind;
        logic [2:0] mode;
        logic [2:0] sel;
    } cas_cmd_type;

    typedef struct packed {
        logic [4:0] lower_chan;
        logic [4:0] upper_chan;
        logic share_stream;
        logic convert;
    } cas_conv_type;

endpackage

// ---- hw/cas_result_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// result store: two write ports, registered read data
module cas_result_mem #(
    parameter int unsigned DEPTH = 18,
    parameter int unsigned WIDTH = 16,
    parameter int unsigned AW = 5
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wa_en_i,
    input wire logic [AW-1:0] wa_addr_i,
    input wire logic [WIDTH-1:0] wa_data_i,
    input wire logic wb_en_i,
    input wire logic [AW-1:0] wb_addr_i,
    input wire logic [WIDTH-1:0] wb_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [WIDTH-1:0] rd_d;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
            if (wa_en_i && wa_addr_i == AW'(i)) begin
                mem_d[i] = wa_data_i;
            end
            if (wb_en_i && wb_addr_i == AW'(i)) begin
                mem_d[i] = wb_data_i;
            end
        end
        rd_d = '0;
        if (32'(rd_addr_i) < DEPTH) begin
            rd_d = mem_q[rd_addr_i];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rd_data_o <= '0;
        end else begin
            mem_q <= mem_d;
            rd_data_o <= rd_d;
        end
    end
endmodule // cas_result_mem
`default_nettype wire

// ---- hw/cas_sequencer.sv ----
// Operation
// - cell command converts selected cells in the selected filter mode
// - all cells: lower converter does cells 1-6, upper does 7-12, together
// - offset calibration follows measuring before the command completes
// - all cells done in 1113, 2335, 201317 us for 27k, 7k, 26 Hz
// - single pair done in 201, 405, 33568 us for 27k, 7k, 26 Hz
// - each converted cell above overvoltage threshold sets its flag
// - each converted cell below undervoltage threshold sets its flag
// - thresholds come from configuration; flags go to status group
// - aux command converts one input, second reference, or all six
// - aux runs on lower converter only, all six take same time as all cells
// - redundant aux feeds lower modulator stream into both filters
// - redundant mismatch stores fault pattern instead of result
// - valid results lie in 0x0000 to 0xDFFF
// - fault low nibble flags mismatching result nibbles, bits 15:8 high
// - fault pattern never has its low four bits all zero
// - redundant aux takes exactly as long as plain aux
// - results are 16-bit unsigned, negatives clamped to zero
// - from standby wait reference power-up unless reference kept on
`timescale 1ns/1ns
`default_nettype none
module cas_sequencer #(
    parameter int unsigned CYC_PER_US = cas_pkg::CYC_PER_US,
    parameter int unsigned REFUP_US = cas_pkg::REFUP_US
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire cas_pkg::cas_cmd_type cmd_i,
    input wire logic keep_reference_on_i,
    input wire logic [15:0] uv_thr_i,
    input wire logic [15:0] ov_thr_i,
    input wire logic signed [16:0] lower_raw_i,
    input wire logic signed [16:0] upper_raw_i,
    input wire logic [4:0] rd_addr_i,
    output logic [15:0] rd_data_o,
    output cas_pkg::cas_conv_type conv_o,
    output logic busy_o,
    output logic ref_up_o,
    output logic [11:0] uv_flags_o,
    output logic [11:0] ov_flags_o
);
    import cas_pkg::*;

    // ============================================================
    // helpers
    function automatic logic [15:0] clamp(input logic signed [16:0] raw);
        logic [15:0] r;
        r = raw[15:0];
        if (raw[16]) begin
            r = 16'h0000;
        end else if (raw[15:0] > RESULT_MAX) begin
            r = RESULT_MAX;
        end
        return r;
    endfunction

    function automatic logic [15:0] redundant(input logic [15:0] a,
                                              input logic [15:0] b);
        logic [3:0] nib;
        logic [15:0] r;
        for (int i = 0; i < 4; i++) begin
            nib[i] = a[i*4 +: 4] != b[i*4 +: 4];
        end
        r = a;
        // a mismatch always leaves a nonzero nibble field
        if (nib != 4'h0) begin
            r = FAULT_BASE | {12'h000, nib};
        end
        return r;
    endfunction

    function automatic logic [TIME_W-1:0] us2cyc(input int unsigned us);
        return TIME_W'(us * CYC_PER_US);
    endfunction

    // ============================================================
    // state
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_REFUP = 4'h2,
        ST_MEAS = 4'h4,
        ST_CAL = 4'h8
    } cas_state_type;

    cas_state_type state_q, state_d;
    cas_cmd_type cmd_q, cmd_d;
    logic [TIME_W-1:0] time_q, time_d;
    logic [2:0] slot_q, slot_d;
    logic ref_q, ref_d;
    logic [11:0] uv_q, uv_d, ov_q, ov_d;

    logic all_sel;
    logic [2:0] last_slot;
    logic [TIME_W-1:0] slot_end, total_end, refup_end;
    logic slot_done;
    logic [4:0] lo_chan, up_chan;
    logic [15:0] lo_res, up_res;
    logic wa_en, wb_en;
    logic [4:0] wa_addr, wb_addr;
    logic [15:0] wa_data, wb_data;

    // ============================================================
    // command decode and timing
    always_comb begin
        if (cmd_q.kind == CAS_CMD_CELLS) begin
            all_sel = cmd_q.sel == CELL_SEL_ALL;
        end else begin
            all_sel = cmd_q.sel >= AUX_SEL_ALL;
        end
        last_slot = all_sel ? 3'(HALF_CELLS - 1) : 3'h0;
        refup_end = us2cyc(REFUP_US);
        // aux uses the same table as cells; redundant uses it too
        if (all_sel) begin
            slot_end = us2cyc(ALL_T1M_US[cmd_q.mode]) *
                       (TIME_W'(slot_q) + 1'b1);
            if (slot_q == last_slot) begin
                slot_end = us2cyc(ALL_T6M_US[cmd_q.mode]);
            end
            total_end = us2cyc(ALL_T6C_US[cmd_q.mode]);
        end else begin
            slot_end = us2cyc(ONE_T1M_US[cmd_q.mode]);
            total_end = us2cyc(ONE_T1C_US[cmd_q.mode]);
        end
        slot_done = state_q == ST_MEAS && time_q + 1'b1 == slot_end;
    end

    // ============================================================
    // channel selection
    always_comb begin
        if (cmd_q.kind == CAS_CMD_CELLS) begin
            if (all_sel) begin
                lo_chan = 5'(slot_q);
            end else begin
                lo_chan = 5'(cmd_q.sel) - 5'h01;
            end
            up_chan = lo_chan + 5'(HALF_CELLS);
        end else begin
            // every aux input goes through the lower converter
            if (all_sel) begin
                lo_chan = 5'(AUX_BASE) + 5'(slot_q);
            end else begin
                lo_chan = 5'(AUX_BASE) + 5'(cmd_q.sel);
            end
            up_chan = lo_chan;
        end
        lo_res = clamp(lower_raw_i);
        up_res = clamp(upper_raw_i);
    end

    // ============================================================
    // result writes and voltage flags
    always_comb begin
        wa_en = slot_done;
        wa_addr = lo_chan;
        wa_data = lo_res;
        wb_en = slot_done && cmd_q.kind == CAS_CMD_CELLS;
        wb_addr = up_chan;
        wb_data = up_res;
        if (cmd_q.kind == CAS_CMD_AUX_RED) begin
            wa_data = redundant(lo_res, up_res);
        end
        uv_d = uv_q;
        ov_d = ov_q;
        if (wb_en) begin
            ov_d[lo_chan[3:0]] = lo_res > ov_thr_i;
            ov_d[up_chan[3:0]] = up_res > ov_thr_i;
            uv_d[lo_chan[3:0]] = lo_res < uv_thr_i;
            uv_d[up_chan[3:0]] = up_res < uv_thr_i;
        end
    end

    // ============================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        time_d = time_q;
        slot_d = slot_q;
        ref_d = ref_q;
        case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    cmd_d = cmd_i;
                    time_d = '0;
                    slot_d = 3'h0;
                    if (ref_q) begin
                        state_d = ST_MEAS;
                    end else begin
                        state_d = ST_REFUP;
                    end
                end
            end
            ST_REFUP: begin
                time_d = time_q + 1'b1;
                if (time_q + 1'b1 >= refup_end) begin
                    ref_d = 1'b1;
                    time_d = '0;
                    state_d = ST_MEAS;
                end
            end
            ST_MEAS: begin
                time_d = time_q + 1'b1;
                if (slot_done) begin
                    if (slot_q == last_slot) begin
                        state_d = ST_CAL;
                    end else begin
                        slot_d = slot_q + 3'h1;
                    end
                end
            end
            ST_CAL: begin
                time_d = time_q + 1'b1;
                if (time_q + 1'b1 >= total_end) begin
                    state_d = ST_IDLE;
                    ref_d = keep_reference_on_i;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            time_q <= '0;
            slot_q <= 3'h0;
            ref_q <= 1'b0;
            uv_q <= 12'h000;
            ov_q <= 12'h000;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            time_q <= time_d;
            slot_q <= slot_d;
            ref_q <= ref_d;
            uv_q <= uv_d;
            ov_q <= ov_d;
        end
    end

    // ============================================================
    // outputs
    always_comb begin
        conv_o.convert = state_q == ST_MEAS;
        conv_o.lower_chan = lo_chan;
        conv_o.upper_chan = up_chan;
        conv_o.share_stream = cmd_q.kind == CAS_CMD_AUX_RED;
        busy_o = state_q != ST_IDLE;
        ref_up_o = ref_q;
        uv_flags_o = uv_q;
        ov_flags_o = ov_q;
    end

    cas_result_mem #(
        .DEPTH(RES_DEPTH),
        .WIDTH(16),
        .AW(5)
    ) u_mem (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .wa_en_i(wa_en),
        .wa_addr_i(wa_addr),
        .wa_data_i(wa_data),
        .wb_en_i(wb_en),
        .wb_addr_i(wb_addr),
        .wb_data_i(wb_data),
        .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o)
    );
endmodule // cas_sequencer
`default_nettype wire

// ---- tb/cas_cell_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// cells and sensor inputs behind the converters
module cas_cell_model (
    input wire logic clk_i,
    input wire cas_pkg::cas_conv_type conv_i,
    input wire logic [15:0] salt_i,
    input wire logic [15:0] err_i,
    output logic signed [16:0] lower_raw_o,
    output logic signed [16:0] upper_raw_o
);
    import cas_pkg::*;
    function automatic logic signed [16:0] level(input logic [4:0] ch);
        return {1'b0, salt_i} + {2'h0, ch, 10'h000} - 17'h01000;
    endfunction
    always @(posedge clk_i) begin
        if (conv_i.convert) begin
            lower_raw_o <= level(conv_i.lower_chan);
            // err_i models a fault in the second filter only
            upper_raw_o <= conv_i.share_stream
                ? level(conv_i.lower_chan) ^ {1'b0, err_i}
                : level(conv_i.upper_chan);
        end else begin
            // nothing valid outside measuring: lines show the inverse level
            lower_raw_o <= ~level(conv_i.lower_chan);
            upper_raw_o <= ~level(conv_i.upper_chan);
        end
    end
endmodule // cas_cell_model
`default_nettype wire

// ---- tb/cas_seq_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// port checker for the sequencer
module cas_seq_chk #(
    parameter int unsigned CYC_PER_US = 10,
    parameter int unsigned REFUP_US = 5000
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire cas_pkg::cas_cmd_type cmd_i,
    input wire logic keep_reference_on_i,
    input wire logic [15:0] uv_thr_i,
    input wire logic [15:0] ov_thr_i,
    input wire logic signed [16:0] lower_raw_i,
    input wire logic signed [16:0] upper_raw_i,
    input wire logic [4:0] rd_addr_i,
    input wire logic [15:0] rd_data_o,
    input wire cas_pkg::cas_conv_type conv_o,
    input wire logic busy_o,
    input wire logic ref_up_o,
    input wire logic [11:0] uv_flags_o,
    input wire logic [11:0] ov_flags_o
);
    import cas_pkg::*;
    logic acc, wide;
    cas_kind_type kind_q, kind_d;
    logic [31:0] exp_q, exp_d, cnt_q, cnt_d;
    // ref state is read at the start: it decides the power-up wait
    always_comb begin
        acc = start_i && !busy_o;
        wide = (cmd_i.kind == CAS_CMD_CELLS) ? (cmd_i.sel == CELL_SEL_ALL)
            : (cmd_i.sel >= AUX_SEL_ALL);
        kind_d = acc ? cmd_i.kind : kind_q;
        exp_d = exp_q;
        if (acc) begin
            exp_d = (ref_up_o ? 32'h0 : REFUP_US * CYC_PER_US) + CYC_PER_US
                * (wide ? ALL_T6C_US[cmd_i.mode] : ONE_T1C_US[cmd_i.mode]);
        end
        cnt_d = busy_o ? cnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            kind_q <= CAS_CMD_CELLS;
            exp_q <= 32'h0;
            cnt_q <= 32'h0;
        end else begin
            kind_q <= kind_d;
            exp_q <= exp_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_BUSY_START: assert property (start_i && !busy_o |=> busy_o)
        else $error("busy did not follow an accepted start");
    AST_RISE_CAUSE: assert property ($rose(busy_o) |-> $past(start_i))
        else $error("busy rose without a start");
    AST_DURATION: assert property ($fell(busy_o) |-> cnt_q == exp_q)
        else $error("command length wrong");
    AST_CONV_IN_BUSY: assert property (conv_o.convert |-> busy_o)
        else $error("converting while idle");
    AST_SPLIT: assert property (conv_o.convert && kind_q == CAS_CMD_CELLS
        |-> conv_o.lower_chan < 5'h6 && conv_o.upper_chan == conv_o.lower_chan + 5'h6)
        else $error("cell halves not paired");
    AST_SHARE: assert property (conv_o.convert
        |-> conv_o.share_stream == (kind_q == CAS_CMD_AUX_RED))
        else $error("stream sharing wrong");
    AST_OV_HOLD: assert property (!busy_o && !$past(busy_o) |-> $stable(ov_flags_o))
        else $error("overvoltage flags moved while idle");
    AST_UV_HOLD: assert property (!busy_o && !$past(busy_o) |-> $stable(uv_flags_o))
        else $error("undervoltage flags moved while idle");
    AST_EXCL: assert property (uv_thr_i < ov_thr_i |-> (uv_flags_o & ov_flags_o) == 12'h0)
        else $error("cell flagged both ways");
    AST_RANGE: assert property (rd_data_o <= RESULT_MAX || rd_data_o[15:4] == 12'hFF0)
        else $error("result out of range");
    AST_FAULT_NZ: assert property (rd_data_o[15:4] == 12'hFF0 |-> rd_data_o[3:0] != 4'h0)
        else $error("fault code with empty nibble mask");
    // reference comes up as measuring starts, else it moves only in idle
    AST_REF_IDLE: assert property ($changed(ref_up_o) |-> !busy_o
        || (ref_up_o && conv_o.convert && !$past(conv_o.convert)))
        else $error("reference state changed mid command");
endmodule // cas_seq_chk
bind cas_sequencer cas_seq_chk #(.CYC_PER_US(CYC_PER_US), .REFUP_US(REFUP_US)) u_chk (.*);
`default_nettype wire

// ---- tb/cas_sequencer_test.sv ----
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// bench
module cas_sequencer_test;
    import cas_pkg::*;
    localparam int unsigned CPU = 1;
    localparam int unsigned RUP = 40;
    typedef struct packed {
        logic [31:0] len;
        logic [11:0] uv;
        logic [11:0] ov;
    } cas_note_type;
    logic clk_i, rstn_i, start_i, keep_reference_on_i, busy_o, ref_up_o;
    cas_cmd_type cmd_i;
    cas_conv_type conv_o;
    logic [15:0] uv_thr_i, ov_thr_i, rd_data_o, salt, err;
    logic signed [16:0] lower_raw_i, upper_raw_i;
    logic [4:0] rd_addr_i;
    logic [11:0] uv_flags_o, ov_flags_o, uv_e, ov_e;
    logic [15:0] mem_e [18];
    logic [17:0] ok_e;
    logic ref_e, rd_stb, rd_v;
    int seed = 32'hDFFE0607;
    int n_fail = 0;
    int samples_checked = 0;
    int cnt = 0;
    cas_note_type noteq[$];
    cas_note_type nt;
    logic [15:0] rdq[$];
    cas_sequencer #(.CYC_PER_US(CPU), .REFUP_US(RUP)) uut (.*);
    cas_cell_model u_cells (.clk_i(clk_i), .conv_i(conv_o), .salt_i(salt),
        .err_i(err), .lower_raw_o(lower_raw_i), .upper_raw_o(upper_raw_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [15:0] val(input int ch);
        logic signed [16:0] r;
        r = {1'b0, salt} + 17'(ch * 1024) - 17'h01000;
        if (r < 0) return 16'h0000;
        if (r > 17'sh0DFFF) return RESULT_MAX;
        return r[15:0];
    endfunction
    task automatic run(input cas_kind_type k, input logic [2:0] m, input logic [2:0] s);
        logic w, h;
        cas_note_type e;
        int n;
        @(negedge clk_i);
        keep_reference_on_i = 1'($random(seed));
        uv_thr_i = 16'($unsigned($random(seed)) % 20000);
        ov_thr_i = uv_thr_i + 16'h4E20 + 16'($unsigned($random(seed)) % 5000);
        if (k == CAS_CMD_AUX_RED)
            salt = 16'h1000 + 16'($random(seed) & 32'h7FFF);
        else
            salt = 16'($unsigned($random(seed)) % 52000);
        cmd_i = '{k, m, s};
        start_i = 1'b1;
        w = (k == CAS_CMD_CELLS) ? (s == CELL_SEL_ALL) : (s >= AUX_SEL_ALL);
        e.len = (ref_e ? 0 : RUP) + CPU * (w ? ALL_T6C_US[m] : ONE_T1C_US[m]);
        ref_e = keep_reference_on_i;
        for (int c = 0; c < 18; c++) begin
            if (k == CAS_CMD_CELLS)
                h = c < 12 && (w || c == s - 1 || c == s + 5);
            else
                h = c >= 12 && (w || c == s + 12);
            if (h) begin
                mem_e[c] = (k == CAS_CMD_AUX_RED && err != 16'h0000)
                    ? {12'hFF0, |err[15:12], |err[11:8], |err[7:4], |err[3:0]}
                    : val(c);
                ok_e[c] = 1'b1;
                if (c < 12) begin
                    uv_e[c] = val(c) < uv_thr_i;
                    ov_e[c] = val(c) > ov_thr_i;
                end
            end
        end
        e.uv = uv_e;
        e.ov = ov_e;
        noteq.push_back(e);
        @(negedge clk_i);
        // start held high into busy, with a changed command: refused
        cmd_i = ~cmd_i;
        @(negedge clk_i);
        start_i = 1'b0;
        for (n = 0; n < 300000 && busy_o !== 1'b0; n++) @(negedge clk_i);
        for (int a = 0; a < 20; a++) begin
            @(negedge clk_i);
            rd_addr_i = 5'(a);
            rd_stb = a >= 18 || ok_e[a % 18];
            if (rd_stb) rdq.push_back(a < 18 ? mem_e[a] : 16'h0000);
        end
        @(negedge clk_i);
        rd_stb = 1'b0;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) rd_v <= rd_stb;
    always @(negedge clk_i) begin
        if (busy_o === 1'b1) begin
            cnt++;
        end else if (cnt > 0) begin
            nt = noteq.pop_front();
            chk(cnt, nt.len);
            chk({uv_flags_o, ov_flags_o}, {nt.uv, nt.ov});
            chk(32'(ref_up_o), 32'(ref_e));
            cnt = 0;
        end
        if (rd_v === 1'b1) chk(rd_data_o, rdq.pop_front());
    end
    initial begin
        #8000000;
        n_fail++;
        conclude();
    end
    initial begin
        {rstn_i, start_i, keep_reference_on_i, rd_stb, ref_e} = 5'h00;
        {cmd_i, uv_thr_i, ov_thr_i, salt, err, rd_addr_i} = '0;
        {uv_e, ov_e, ok_e} = '0;
        repeat (12) @(negedge clk_i);
        rstn_i = 1'b1;
        for (int m = 0; m < 8; m++) run(CAS_CMD_CELLS, 3'(m), 3'(m % 6 + 1));
        run(CAS_CMD_CELLS, 3'h0, CELL_SEL_ALL);
        run(CAS_CMD_CELLS, 3'h2, CELL_SEL_ALL);
        for (int s = 0; s < 8; s++) run(CAS_CMD_AUX, 3'h0, 3'(s));
        run(CAS_CMD_AUX_RED, 3'h1, AUX_SEL_ALL);
        err = 16'h1000;
        run(CAS_CMD_AUX_RED, 3'h0, AUX_SEL_ALL);
        err = 16'($random(seed) & 32'h1111) | 16'h0001;
        run(CAS_CMD_AUX_RED, 3'h2, 3'h3);
        repeat (3) @(negedge clk_i);
        conclude();
    end
endmodule // cas_sequencer_test
`default_nettype wire
